// file: rtl/swc_pkg.sv
/*
 * Shared constants and carrier types for the sleep and wake controller.
 * Assumes a single 100 MHz clock domain and an 8-bit register port.
 */
`default_nettype none
package swc_pkg;
	// Register port offsets
	localparam logic [7:0] ADDR_PIN_CHANGE_EN = 8'h00;
	localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h01;
	localparam logic [7:0] ADDR_PERIPH_EN_ONE = 8'h02;
	localparam logic [7:0] ADDR_PERIPH_EN_TWO = 8'h03;
	localparam logic [7:0] ADDR_PERIPH_FLAGS_ONE = 8'h04;
	localparam logic [7:0] ADDR_PERIPH_FLAGS_TWO = 8'h05;
	localparam logic [7:0] ADDR_POWER_STATUS = 8'h06;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h07;
	localparam logic [7:0] ADDR_EVENT_CLEAR = 8'h08;
	localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h09;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_EVENTS = 4'h0;
	localparam logic RST_POWERDOWN_FLAG = 1'b1;
	localparam logic RST_TIMEOUT_FLAG = 1'b1;
	// Interrupt control layout
	localparam int BIT_GLOBAL_IRQ_EN = 7;
	localparam int BIT_PERIPH_IRQ_EN = 6;
	// Wake-capable flag masks; others cannot set while clocks are stopped
	localparam logic [2:0] WAKE_MASK_CTRL = 3'h3;
	localparam logic [7:0] WAKE_MASK_ONE_FIXED = 8'h04;
	localparam logic [7:0] WAKE_MASK_TWO = 8'h01;
	localparam int BIT_FIRST_TIMER = 0;
	localparam int BIT_SERIAL_PORT = 3;
	localparam int BIT_SERIAL_RX = 5;
	localparam int BIT_CONVERSION = 6;
	// Event status bits
	localparam int EV_SLEPT = 0;
	localparam int EV_WOKE = 1;
	localparam int EV_SKIPPED = 2;
	localparam int EV_EXT_RESET = 3;
	// Interrupt vector taken after an interrupt wake with global enable set
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam logic [12:0] PC_STEP = 13'h0001;

	typedef enum {ST_RUN, ST_SLEEP, ST_OSC_WAIT, ST_RESUME} swc_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} swc_reg_req_type;

	typedef struct packed {
		logic [2:0] ctrl_set;
		logic [7:0] one_set;
		logic [7:0] two_set;
	} swc_flag_set_type;

	typedef struct packed {
		logic first_timer_async;
		logic serial_rx_sync_slave;
		logic conversion_rc_clock;
		logic sync_serial_port_slave;
	} swc_wake_mode_type;
endpackage
`default_nettype wire

// file: rtl/swc_sleep_ctrl.sv
/*
 * Sleep and wake controller: enters power-down on the sleep instruction,
 * gates the main oscillator, holds the pins and keeps the status flags.
 * Assumes core, watchdog and interrupt sources on ref_clk; the external
 * reset pin and oscillator-ready level arrive asynchronously.
 */
// Chosen here: the plain strobed port and the placing of the registers.
`default_nettype none
module swc_sleep_ctrl
	import swc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire swc_pkg::swc_reg_req_type reg_req,
	output logic [7:0] reg_rdata,
	// Core side
	input wire logic sleep_exec,
	input wire logic watchdog_clear_instruction,
	input wire logic [12:0] pc,
	output logic prefetch_valid,
	output logic [12:0] prefetch_addr,
	output logic core_stall,
	output logic resume_pulse,
	output logic vector_take,
	output logic [12:0] vector_addr,
	// Watchdog
	input wire logic watchdog_enable,
	input wire logic watchdog_timeout,
	output logic watchdog_clear,
	// Interrupt sources
	input wire swc_pkg::swc_flag_set_type flag_set,
	input wire swc_pkg::swc_wake_mode_type wake_mode,
	output logic [7:0] pin_change_enable,
	// Clock and pins
	input wire logic osc_ready,
	input wire logic external_reset_pin_n,
	output logic external_reset_pin_out,
	output logic external_reset_pin_oe,
	output logic main_osc_enable,
	output logic io_hold,
	output logic device_reset,
	output logic powerdown_flag,
	output logic timeout_flag,
	// Interrupt to the system
	output logic irq
);
	import swc_pkg::*;

	// Pin and oscillator synchronisers; stage one feeds only stage two
	logic [1:0] ext_rst_meta;
	logic [1:0] osc_meta;
	logic ext_rst_n_s;
	logic osc_ready_s;
	always_ff @(posedge ref_clk) begin
		ext_rst_meta <= {ext_rst_meta[0], external_reset_pin_n};
		osc_meta <= {osc_meta[0], osc_ready};
	end
	assign ext_rst_n_s = ext_rst_meta[1];
	assign osc_ready_s = osc_meta[1];

	// Register state
	logic [7:0] int_ctrl, next_int_ctrl;
	logic [7:0] en_one, next_en_one;
	logic [7:0] en_two, next_en_two;
	logic [7:0] fl_one, next_fl_one;
	logic [7:0] fl_two, next_fl_two;
	logic [7:0] next_pin_change_enable;
	logic [3:0] ev_status, next_ev_status;
	logic [3:0] ev_enable, next_ev_enable;
	logic [7:0] next_reg_rdata;
	logic next_irq;
	// Sequencer state
	swc_state_type state, next_state;
	logic woke_by_irq, next_woke_by_irq;
	logic next_powerdown_flag, next_timeout_flag, next_watchdog_clear;
	logic next_prefetch_valid, next_core_stall, next_resume_pulse, next_vector_take;
	logic next_main_osc_enable, next_io_hold, next_device_reset;
	logic [12:0] next_prefetch_addr;
	logic [3:0] ev_hit;
	logic asleep;
	logic [2:0] wake_mask_ctrl;
	logic [7:0] wake_mask_one;
	logic wake_pending;

	// True when some source has both enable and flag set
	function automatic logic any_pending(input logic [7:0] ctrl, input logic [7:0] e1,
			input logic [7:0] f1, input logic [7:0] e2, input logic [7:0] f2);
		any_pending = |(ctrl[5:3] & ctrl[2:0]) | |(e1 & f1) | |(e2 & f2);
	endfunction

	assign asleep = (state == ST_SLEEP) || (state == ST_OSC_WAIT);
	// Sources that keep running without clocks; mode qualifiers come from peripherals
	assign wake_mask_ctrl = asleep ? WAKE_MASK_CTRL : 3'h7;
	always_comb begin
		wake_mask_one = WAKE_MASK_ONE_FIXED;
		wake_mask_one[BIT_FIRST_TIMER] = wake_mode.first_timer_async;
		wake_mask_one[BIT_SERIAL_PORT] = wake_mode.sync_serial_port_slave;
		wake_mask_one[BIT_SERIAL_RX] = wake_mode.serial_rx_sync_slave;
		wake_mask_one[BIT_CONVERSION] = wake_mode.conversion_rc_clock;
		if (!asleep) begin
			wake_mask_one = 8'hFF;
		end
	end
	assign wake_pending = any_pending(int_ctrl, en_one, fl_one, en_two, fl_two);

	// Register next values; hardware set wins over a software write
	always_comb begin
		next_int_ctrl = int_ctrl;
		next_en_one = en_one;
		next_en_two = en_two;
		next_fl_one = fl_one;
		next_fl_two = fl_two;
		next_pin_change_enable = pin_change_enable;
		next_ev_enable = ev_enable;
		next_ev_status = ev_status;
		next_reg_rdata = 8'h00;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				ADDR_PIN_CHANGE_EN: next_pin_change_enable = reg_req.wdata;
				ADDR_INTERRUPT_CONTROL: next_int_ctrl = reg_req.wdata;
				ADDR_PERIPH_EN_ONE: next_en_one = reg_req.wdata;
				ADDR_PERIPH_EN_TWO: next_en_two = reg_req.wdata & WAKE_MASK_TWO;
				ADDR_PERIPH_FLAGS_ONE: next_fl_one = reg_req.wdata;
				ADDR_PERIPH_FLAGS_TWO: next_fl_two = reg_req.wdata & WAKE_MASK_TWO;
				ADDR_EVENT_CLEAR: next_ev_status = ev_status & ~reg_req.wdata[3:0];
				ADDR_EVENT_ENABLE: next_ev_enable = reg_req.wdata[3:0];
				default: ;
			endcase
		end
		// Only wake-capable sources may set flags while the clocks are stopped
		next_int_ctrl[2:0] = next_int_ctrl[2:0] | (flag_set.ctrl_set & wake_mask_ctrl);
		next_fl_one = next_fl_one | (flag_set.one_set & wake_mask_one);
		next_fl_two = next_fl_two | (flag_set.two_set & WAKE_MASK_TWO);
		next_ev_status = next_ev_status | ev_hit;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				ADDR_PIN_CHANGE_EN: next_reg_rdata = pin_change_enable;
				ADDR_INTERRUPT_CONTROL: next_reg_rdata = int_ctrl;
				ADDR_PERIPH_EN_ONE: next_reg_rdata = en_one;
				ADDR_PERIPH_EN_TWO: next_reg_rdata = en_two;
				ADDR_PERIPH_FLAGS_ONE: next_reg_rdata = fl_one;
				ADDR_PERIPH_FLAGS_TWO: next_reg_rdata = fl_two;
				ADDR_POWER_STATUS: next_reg_rdata = {4'h0, io_hold, main_osc_enable,
					timeout_flag, powerdown_flag};
				ADDR_EVENT_STATUS: next_reg_rdata = {4'h0, ev_status};
				ADDR_EVENT_ENABLE: next_reg_rdata = {4'h0, ev_enable};
				default: next_reg_rdata = 8'h00;
			endcase
		end
		next_irq = |(next_ev_status & next_ev_enable);
	end

	// Register state update
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			int_ctrl <= RST_BYTE;
			en_one <= RST_BYTE;
			en_two <= RST_BYTE;
			fl_one <= RST_BYTE;
			fl_two <= RST_BYTE;
			pin_change_enable <= RST_BYTE;
			ev_status <= RST_EVENTS;
			ev_enable <= RST_EVENTS;
			reg_rdata <= RST_BYTE;
			irq <= 1'b0;
		end else begin
			int_ctrl <= next_int_ctrl;
			en_one <= next_en_one;
			en_two <= next_en_two;
			fl_one <= next_fl_one;
			fl_two <= next_fl_two;
			pin_change_enable <= next_pin_change_enable;
			ev_status <= next_ev_status;
			ev_enable <= next_ev_enable;
			reg_rdata <= next_reg_rdata;
			irq <= next_irq;
		end
	end

	// Sleep sequencer next values
	always_comb begin
		next_state = state;
		next_woke_by_irq = woke_by_irq;
		next_powerdown_flag = powerdown_flag;
		next_timeout_flag = timeout_flag;
		next_watchdog_clear = 1'b0;
		next_prefetch_valid = 1'b0;
		next_prefetch_addr = prefetch_addr;
		next_core_stall = core_stall;
		next_resume_pulse = 1'b0;
		next_vector_take = 1'b0;
		next_main_osc_enable = main_osc_enable;
		next_io_hold = io_hold;
		next_device_reset = !ext_rst_n_s;
		ev_hit = 4'h0;
		unique case (state)
			ST_RUN: begin
				if (watchdog_clear_instruction) begin
					next_watchdog_clear = 1'b1;
					next_powerdown_flag = 1'b1;
					next_timeout_flag = 1'b1;
				end
				if (sleep_exec) begin
					next_prefetch_valid = 1'b1;
					next_prefetch_addr = pc + PC_STEP;
					if (wake_pending) begin
						ev_hit[EV_SKIPPED] = 1'b1;
					end else begin
						next_state = ST_SLEEP;
						next_watchdog_clear = watchdog_enable;
						next_powerdown_flag = 1'b0;
						next_timeout_flag = 1'b1;
						next_main_osc_enable = 1'b0;
						next_io_hold = 1'b1;
						next_core_stall = 1'b1;
						ev_hit[EV_SLEPT] = 1'b1;
					end
				end
			end
			ST_SLEEP: begin
				// Entry is already complete here, so a late interrupt still wakes
				if (!ext_rst_n_s) begin
					next_state = ST_RUN;
					next_main_osc_enable = 1'b1;
					next_io_hold = 1'b0;
					next_core_stall = 1'b0;
					ev_hit[EV_EXT_RESET] = 1'b1;
				end else if (watchdog_timeout || wake_pending) begin
					next_state = ST_OSC_WAIT;
					next_woke_by_irq = !watchdog_timeout;
					next_timeout_flag = !watchdog_timeout;
					next_watchdog_clear = 1'b1;
					next_main_osc_enable = 1'b1;
				end
			end
			ST_OSC_WAIT: begin
				if (!ext_rst_n_s) begin
					next_state = ST_RUN;
					next_io_hold = 1'b0;
					next_core_stall = 1'b0;
					ev_hit[EV_EXT_RESET] = 1'b1;
				end else if (osc_ready_s) begin
					next_state = ST_RESUME;
				end
			end
			ST_RESUME: begin
				next_state = ST_RUN;
				next_io_hold = 1'b0;
				next_core_stall = 1'b0;
				next_resume_pulse = 1'b1;
				next_vector_take = woke_by_irq && int_ctrl[BIT_GLOBAL_IRQ_EN];
				ev_hit[EV_WOKE] = 1'b1;
			end
		endcase
	end

	// Sequencer registers; the pin driver is never enabled
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= ST_RUN;
			woke_by_irq <= 1'b0;
			powerdown_flag <= RST_POWERDOWN_FLAG;
			timeout_flag <= RST_TIMEOUT_FLAG;
			watchdog_clear <= 1'b0;
			prefetch_valid <= 1'b0;
			prefetch_addr <= 13'h0000;
			core_stall <= 1'b0;
			resume_pulse <= 1'b0;
			vector_take <= 1'b0;
			vector_addr <= IRQ_VECTOR;
			main_osc_enable <= 1'b1;
			io_hold <= 1'b0;
			device_reset <= 1'b0;
			external_reset_pin_out <= 1'b0;
			external_reset_pin_oe <= 1'b1;
		end else begin
			state <= next_state;
			woke_by_irq <= next_woke_by_irq;
			powerdown_flag <= next_powerdown_flag;
			timeout_flag <= next_timeout_flag;
			watchdog_clear <= next_watchdog_clear;
			prefetch_valid <= next_prefetch_valid;
			prefetch_addr <= next_prefetch_addr;
			core_stall <= next_core_stall;
			resume_pulse <= next_resume_pulse;
			vector_take <= next_vector_take;
			vector_addr <= IRQ_VECTOR;
			main_osc_enable <= next_main_osc_enable;
			io_hold <= next_io_hold;
			device_reset <= next_device_reset;
			external_reset_pin_out <= 1'b0;
			external_reset_pin_oe <= 1'b1;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_skip_keeps_flags: assert property ((state == ST_RUN) && sleep_exec && wake_pending
		&& !watchdog_clear_instruction |=> (state == ST_RUN) && !watchdog_clear
		&& $stable(powerdown_flag) && $stable(timeout_flag))
		else $error("sleep with pending interrupt did not act as a no-op");
	a_entry_flags_set: assert property ((state == ST_RUN) && sleep_exec && !wake_pending
		|=> (state == ST_SLEEP) && !powerdown_flag && timeout_flag)
		else $error("sleep entry flags wrong");
	a_entry_wdt_clear: assert property ((state == ST_RUN) && sleep_exec && !wake_pending
		|=> watchdog_clear == $past(watchdog_enable))
		else $error("watchdog not cleared on sleep entry");
	a_osc_off_asleep: assert property ((state == ST_SLEEP) |-> !main_osc_enable)
		else $error("main oscillator running while asleep");
	a_io_hold_asleep: assert property (asleep |-> io_hold && core_stall)
		else $error("pins released during sleep");
	a_pin_not_driven: assert property (external_reset_pin_oe)
		else $error("external reset pin driven");
	a_ext_reset_out: assert property ((state == ST_SLEEP) && !ext_rst_n_s
		|=> device_reset && (state == ST_RUN) && !resume_pulse)
		else $error("external reset in sleep not applied");
	a_wdt_wake_flag: assert property ((state == ST_SLEEP) && ext_rst_n_s && watchdog_timeout
		|=> !timeout_flag && watchdog_clear && main_osc_enable)
		else $error("watchdog wake did not clear time-out flag");
	a_wake_wdt_clear: assert property ((state == ST_SLEEP) && (next_state == ST_OSC_WAIT)
		|=> watchdog_clear)
		else $error("wake did not clear the watchdog");
	a_prefetch_addr: assert property ((state == ST_RUN) && sleep_exec
		|=> prefetch_valid && (prefetch_addr == 13'($past(pc) + PC_STEP)))
		else $error("prefetch address wrong");
	a_irq_wakes_fast: assert property ((state == ST_SLEEP) && wake_pending && ext_rst_n_s
		|=> (state == ST_OSC_WAIT))
		else $error("pending enabled interrupt did not wake");
	a_resume_after_osc: assert property (resume_pulse |-> $past(osc_ready_s, 2)
		&& main_osc_enable)
		else $error("resumed before oscillator ready");
	a_vector_on_gie: assert property (resume_pulse && $past(woke_by_irq)
		|-> vector_take == $past(int_ctrl[BIT_GLOBAL_IRQ_EN]))
		else $error("vector choice after wake wrong");
	a_blocked_source: assert property (asleep && !fl_one[1] && !reg_req.wr
		|=> !fl_one[1])
		else $error("stopped peripheral raised a flag in sleep");
	a_wdt_no_reset: assert property ((state == ST_SLEEP) && ext_rst_n_s && watchdog_timeout
		|=> !device_reset && !resume_pulse)
		else $error("watchdog wake applied a device reset");
	a_resume_unstalls: assert property (resume_pulse |-> !core_stall && !io_hold)
		else $error("core still held at resume");

	c_sleep_skipped: cover property ((state == ST_RUN) && sleep_exec && wake_pending);
	c_irq_wake_vector: cover property (resume_pulse && vector_take);
	c_wdt_wake: cover property ((state == ST_SLEEP) && watchdog_timeout ##1 !timeout_flag);
	c_ext_reset_sleep: cover property ((state == ST_SLEEP) && !ext_rst_n_s);
	c_late_irq_sleep: cover property ((state == ST_RUN) && sleep_exec && !wake_pending
		&& flag_set.two_set[0] ##2 (state == ST_OSC_WAIT));
endmodule
`default_nettype wire

// file: dv/swc_osc_model.sv
/*
 * Behavioural model of the main oscillator beside the sleep controller.
 * Assumes main_osc_enable comes from the controller on ref_clk.
 */
`default_nettype none
module swc_osc_model #(
	parameter int OSC_DELAY = 5
) (
	// Clock
	input wire logic ref_clk,
	// Oscillator control and status
	input wire logic main_osc_enable,
	output logic osc_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ready settles to low at the first edge, while the controller is still in reset
	int cnt = 0;

	// Startup takes several cycles, so the controller must wait for ready
	always @(posedge ref_clk) begin
		if (main_osc_enable !== 1'b1) begin
			cnt <= 0;
			osc_ready <= 1'b0;
		end else if (cnt < OSC_DELAY) begin
			cnt <= cnt + 1;
		end else begin
			osc_ready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
 * Self-checking bench for the sleep and wake controller.
 * Assumes the oscillator model answers on ref_clk; reset is synchronous.
 */
`default_nettype none
module tb_top;
	import swc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, reset = 1'b1, sleep_exec = 1'b0, wdi = 1'b0, wdt_to = 1'b0;
	logic ext_n = 1'b1, osc_ready, vt;
	logic [12:0] pc = 13'h0000;
	swc_reg_req_type req = '0;
	swc_flag_set_type fs = '0;
	logic wd_en = 1'b1;
	swc_wake_mode_type wm = '0;
	logic [7:0] rdata, pce;
	logic pf_v, stall, resume, vtake, wclr, osc_en, hold, dev_rst, pd, to, irq, pin_out, pin_oe;
	logic [12:0] pf_a, vaddr;
	int mismatches = 0, compares = 0, wc;

	always #5 ref_clk = ~ref_clk;

	swc_sleep_ctrl u_swc_sleep_ctrl (.ref_clk(ref_clk), .reset(reset), .reg_req(req),
		.reg_rdata(rdata), .sleep_exec(sleep_exec), .watchdog_clear_instruction(wdi),
		.pc(pc), .prefetch_valid(pf_v), .prefetch_addr(pf_a), .core_stall(stall),
		.resume_pulse(resume), .vector_take(vtake), .vector_addr(vaddr),
		.watchdog_enable(wd_en), .watchdog_timeout(wdt_to), .watchdog_clear(wclr),
		.flag_set(fs), .wake_mode(wm), .pin_change_enable(pce), .osc_ready(osc_ready),
		.external_reset_pin_n(ext_n), .external_reset_pin_out(pin_out),
		.external_reset_pin_oe(pin_oe), .main_osc_enable(osc_en), .io_hold(hold),
		.device_reset(dev_rst), .powerdown_flag(pd), .timeout_flag(to), .irq(irq));
	swc_osc_model u_swc_osc_model (.ref_clk(ref_clk), .main_osc_enable(osc_en),
		.osc_ready(osc_ready));

	// Single comparison point for every checked value
	task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge ref_clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1 chk(name, {5'h00, exp}, {5'h00, rdata});
	endtask

	task automatic pulse_sleep(input logic [12:0] p);
		@(posedge ref_clk);
		sleep_exec <= 1'b1;
		pc <= p;
		@(posedge ref_clk);
		sleep_exec <= 1'b0;
		#1;
	endtask

	// Bounded wait for resume, counting watchdog clears on the way
	task automatic wait_resume();
		wc = 0;
		// A watchdog wake raises the clear in the cycle the caller has just seen
		#1;
		for (int i = 0; i < 60 && resume !== 1'b1; i++) begin
			if (wclr === 1'b1) wc++;
			@(posedge ref_clk);
			#1;
		end
		vt = vtake;
		chk("resume", 13'h1, {12'h0, resume});
	endtask

	task automatic t_reset_values();
		rd(ADDR_POWER_STATUS, 8'h07, "power status");
		rd(8'h0F, 8'h00, "unmapped");
		chk("pin oe", 13'h1, {12'h0, pin_oe});
		$display("test reset_values done");
	endtask

	task automatic t_irq_wake();
		wr(ADDR_INTERRUPT_CONTROL, 8'h88);
		pulse_sleep(13'h0100);
		chk("prefetch valid", 13'h1, {12'h0, pf_v});
		chk("prefetch addr", 13'h0101, pf_a);
		chk("stall", 13'h1, {12'h0, stall});
		chk("osc off", 13'h0, {12'h0, osc_en});
		chk("io hold", 13'h1, {12'h0, hold});
		chk("flags", 13'h2, {11'h0, to, pd});
		chk("wdt clear entry", 13'h1, {12'h0, wclr});
		@(posedge ref_clk);
		fs.ctrl_set <= 3'h1;
		@(posedge ref_clk);
		fs.ctrl_set <= 3'h0;
		wait_resume();
		chk("vector take", 13'h1, {12'h0, vt});
		chk("vector addr", 13'h0004, vaddr);
		chk("wake clears", 13'h1, wc[12:0]);
		chk("hold off", 13'h0, {12'h0, hold});
		wr(ADDR_INTERRUPT_CONTROL, 8'h00);
		$display("test irq_wake done");
	endtask

	task automatic t_wdt_wake();
		pulse_sleep(13'h0200);
		@(posedge ref_clk);
		wdt_to <= 1'b1;
		@(posedge ref_clk);
		wdt_to <= 1'b0;
		wait_resume();
		chk("timeout flag", 13'h0, {12'h0, to});
		chk("no vector", 13'h0, {12'h0, vt});
		chk("no reset", 13'h0, {12'h0, dev_rst});
		chk("wake clears", 13'h1, wc[12:0]);
		$display("test wdt_wake done");
	endtask

	task automatic t_sleep_skipped();
		@(posedge ref_clk);
		wdi <= 1'b1;
		@(posedge ref_clk);
		wdi <= 1'b0;
		wr(ADDR_INTERRUPT_CONTROL, 8'h08);
		@(posedge ref_clk);
		fs.ctrl_set <= 3'h1;
		@(posedge ref_clk);
		fs.ctrl_set <= 3'h0;
		pulse_sleep(13'h0300);
		chk("skip prefetch", 13'h1, {12'h0, pf_v});
		chk("skip stall", 13'h0, {12'h0, stall});
		chk("skip wdt", 13'h0, {12'h0, wclr});
		chk("skip flags", 13'h3, {11'h0, to, pd});
		chk("skip osc", 13'h1, {12'h0, osc_en});
		wr(ADDR_INTERRUPT_CONTROL, 8'h00);
		$display("test sleep_skipped done");
	endtask

	task automatic t_no_wake_ext_reset();
		wr(ADDR_PERIPH_EN_ONE, 8'h02);
		wr(ADDR_INTERRUPT_CONTROL, 8'h80);
		pulse_sleep(13'h0400);
		@(posedge ref_clk);
		fs.ctrl_set <= 3'h1;
		fs.one_set <= 8'h02;
		@(posedge ref_clk);
		fs <= '0;
		repeat (20) @(posedge ref_clk);
		#1 chk("still asleep", 13'h1, {12'h0, stall});
		chk("no timer two", 13'h0, {12'h0, resume});
		@(posedge ref_clk);
		ext_n <= 1'b0;
		// Two synchroniser stages plus the output register
		repeat (2) @(posedge ref_clk);
		#1 chk("reset not early", 13'h0, {12'h0, dev_rst});
		@(posedge ref_clk);
		#1 chk("device reset", 13'h1, {12'h0, dev_rst});
		@(posedge ref_clk);
		ext_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 chk("osc back", 13'h1, {12'h0, osc_en});
		chk("reset released", 13'h0, {12'h0, dev_rst});
		chk("hold released", 13'h0, {12'h0, hold});
		chk("pin not driven", 13'h1, {12'h0, pin_oe});
		$display("test no_wake_ext_reset done");
	endtask

	// Clockless wake sources, watchdog disabled, and a flag raised with the sleep itself
	task automatic t_wake_sources();
		wr(ADDR_PIN_CHANGE_EN, 8'hA5);
		rd(ADDR_PIN_CHANGE_EN, 8'hA5, "pin change reg");
		chk("pin change out", 13'h00A5, {5'h00, pce});
		chk("reset pin level", 13'h0, {12'h0, pin_out});
		wr(ADDR_INTERRUPT_CONTROL, 8'h00);
		wr(ADDR_PERIPH_EN_ONE, 8'h01);
		wr(ADDR_PERIPH_EN_TWO, 8'h01);
		wd_en <= 1'b0;
		wm.first_timer_async <= 1'b1;
		pulse_sleep(13'h0500);
		chk("entry no wdt clear", 13'h0, {12'h0, wclr});
		@(posedge ref_clk);
		fs.one_set <= 8'h41;
		@(posedge ref_clk);
		fs.one_set <= 8'h00;
		wait_resume();
		chk("timer wake no vector", 13'h0, {12'h0, vt});
		chk("timer wake clears", 13'h1, wc[12:0]);
		rd(ADDR_PERIPH_FLAGS_ONE, 8'h01, "flags one");
		wr(ADDR_PERIPH_FLAGS_ONE, 8'h00);
		@(posedge ref_clk);
		sleep_exec <= 1'b1;
		pc <= 13'h0600;
		fs.two_set <= 8'h01;
		@(posedge ref_clk);
		sleep_exec <= 1'b0;
		fs.two_set <= 8'h00;
		#1 chk("late irq sleeps", 13'h1, {12'h0, stall});
		wait_resume();
		chk("late irq flags", 13'h2, {11'h0, to, pd});
		chk("capture wake clears", 13'h1, wc[12:0]);
		rd(ADDR_PERIPH_FLAGS_TWO, 8'h01, "flags two");
		wr(ADDR_PERIPH_FLAGS_TWO, 8'h00);
		wr(ADDR_PERIPH_EN_ONE, 8'h00);
		wr(ADDR_PERIPH_EN_TWO, 8'h00);
		wd_en <= 1'b1;
		wm <= '0;
		$display("test wake_sources done");
	endtask

	task automatic t_events();
		rd(ADDR_EVENT_STATUS, 8'h0F, "event status");
		chk("masked irq", 13'h0, {12'h0, irq});
		wr(ADDR_EVENT_ENABLE, 8'h02);
		repeat (2) @(posedge ref_clk);
		#1 chk("irq raised", 13'h1, {12'h0, irq});
		wr(ADDR_EVENT_CLEAR, 8'h02);
		repeat (2) @(posedge ref_clk);
		#1 chk("irq cleared", 13'h0, {12'h0, irq});
		rd(ADDR_EVENT_STATUS, 8'h0D, "status after clear");
		$display("test events done");
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence; the watchdog allows several times the expected run
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset_values();
		t_irq_wake();
		t_wdt_wake();
		t_sleep_skipped();
		t_no_wake_ext_reset();
		t_wake_sources();
		t_events();
		give_verdict();
	end

	initial begin
		#20000;
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire
